/* hw/atsrf_top.sv */
// atsrf_top: trigger selection, go bit and result formatting with AHB-Lite registers
// assumes an external converter core that takes start_o and reports done or abort
// assumes timer events are single-cycle pulses synchronous to clock_i
`timescale 1ns/10ps
module atsrf_top
  import atsrf_pkg::*;
(
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic eight_bit_overflow_i,
  input wire logic sixteen_bit_overflow_i,
  input wire logic period_match_i,
  input wire logic external_trigger_pin_i,
  output logic eight_bit_overflow_flag_o,
  output logic sixteen_bit_overflow_flag_o,
  output logic period_match_flag_o,
  output logic start_o,
  input wire logic conv_done_i,
  input wire logic conv_abort_i,
  input wire logic [ATSRF_RES_W-1:0] conv_value_i,
  input wire logic [3:0] conv_bits_done_i,
  output logic conversion_go_flag_o,
  output logic conversion_done_flag_o,
  output logic irq_o
);
  typedef enum logic [1:0] {ATSRF_IDLE, ATSRF_BUSY} atsrf_state_type;

  // programmer-visible state
  atsrf_state_type state;
  logic [7:0] auto_trigger_control;
  logic [7:0] result_high;
  logic [7:0] result_low;
  logic result_justify_select;
  logic conversion_go_flag;
  logic [2:0] status;
  logic [2:0] mask;
  // trigger path
  logic pin_rise;
  logic pin_fall;
  logic trig_event;
  logic sw_go;
  logic sw_stop;
  logic load_result;
  logic [ATSRF_RES_W-1:0] load_value;
  // bus decode
  logic wr_pend;
  logic [7:0] wr_addr;
  logic rd_en;
  logic wr_ctrl;
  logic wr_resh;
  logic wr_resl;
  logic wr_cfg;
  logic wr_stat;
  logic wr_mask;
  // status and result helpers
  logic [2:0] next_status;
  logic [2:0] status_set;
  logic [2:0] auto_sel;
  logic [ATSRF_RES_W-1:0] partial;
  logic busy;
  logic conv_end;
  logic conv_cut;
  logic [5:0] wr_sel;
  logic [5:0] rd_sel;
  logic [31:0] next_hrdata;
  logic [15:0] formatted;

  // fill every unconverted low bit with the last converted one
  function automatic logic [ATSRF_RES_W-1:0] atsrf_fill(
    input logic [ATSRF_RES_W-1:0] value,
    input logic [3:0] bits_done
  );
    logic [ATSRF_RES_W-1:0] r;
    logic last_bit;
    r = value;
    // with no bit converted the msb fills the whole word
    last_bit = value[ATSRF_RES_W-1];
    for (int i = ATSRF_RES_W - 1; i >= 0; i--) begin
      if ((ATSRF_RES_W - 1 - i) < int'(bits_done)) begin
        last_bit = value[i];
      end else begin
        r[i] = last_bit;
      end
    end
    return r;
  endfunction : atsrf_fill

  // split a value into high and low bytes for the chosen justification
  function automatic logic [15:0] atsrf_format(
    input logic [ATSRF_RES_W-1:0] value,
    input logic right
  );
    logic [15:0] r;
    if (right) begin
      r = {6'h00, value[9:8], value[7:0]};
    end else begin
      r = {value[9:2], value[1:0], 6'h00};
    end
    return r;
  endfunction : atsrf_format

  // one-hot register select from the low address byte
  function automatic logic [5:0] atsrf_decode(
    input logic [7:0] addr
  );
    logic [5:0] sel;
    sel = 6'h00;
    // offsets beyond the map select nothing, so writes there are dropped
    case (addr)
      ATSRF_OFS_CTRL: sel = 6'h01;
      ATSRF_OFS_RESH: sel = 6'h02;
      ATSRF_OFS_RESL: sel = 6'h04;
      ATSRF_OFS_CFG: sel = 6'h08;
      ATSRF_OFS_STAT: sel = 6'h10;
      ATSRF_OFS_MASK: sel = 6'h20;
      default: sel = 6'h00;
    endcase
    return sel;
  endfunction : atsrf_decode

  atsrf_trig_sync u_sync (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .pin_i(external_trigger_pin_i),
    .rise_o(pin_rise),
    .fall_o(pin_fall)
  );

  // timer flags follow their events whatever the trigger selection is
  // the flags are plain copies; the timers' own flag registers sit outside
  assign eight_bit_overflow_flag_o = eight_bit_overflow_i;
  assign sixteen_bit_overflow_flag_o = sixteen_bit_overflow_i;
  assign period_match_flag_o = period_match_i;

  // trigger source mux; reserved codes and 000 fall to no trigger
  // pin edges arrive as one-cycle pulses, so a held pin level starts only one run
  assign auto_sel = auto_trigger_control[ATSRF_SEL_MSB:ATSRF_SEL_LSB];
  always_comb begin
    case (auto_sel)
      ATSRF_TRG_NONE: trig_event = 1'b0;
      ATSRF_TRG_T8: trig_event = eight_bit_overflow_i;
      ATSRF_TRG_T16: trig_event = sixteen_bit_overflow_i;
      ATSRF_TRG_PM: trig_event = period_match_i;
      ATSRF_TRG_RISE: trig_event = pin_rise;
      ATSRF_TRG_FALL: trig_event = pin_fall;
      default: trig_event = 1'b0;
    endcase
  end

  // bus address phase capture; zero wait states, so hreadyout stays high
  // hsize is not checked: every register is one whole word
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign rd_en = hsel_i & hready_i & htrans_i[1] & ~hwrite_i;

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else begin
      wr_pend <= hsel_i & hready_i & htrans_i[1] & hwrite_i;
      wr_addr <= haddr_i[7:0];
    end
  end

  // data phase write strobes, one per register
  assign wr_sel = wr_pend ? atsrf_decode(wr_addr) : 6'h00;
  assign wr_ctrl = wr_sel[0];
  assign wr_resh = wr_sel[1];
  assign wr_resl = wr_sel[2];
  assign wr_cfg = wr_sel[3];
  assign wr_stat = wr_sel[4];
  assign wr_mask = wr_sel[5];
  assign sw_go = wr_cfg & hwdata_i[ATSRF_CFG_GO];
  assign sw_stop = wr_cfg & ~hwdata_i[ATSRF_CFG_GO];

  // read data chosen from the address phase; unmapped reads give zero
  assign rd_sel = atsrf_decode(haddr_i[7:0]);
  always_comb begin
    next_hrdata = 32'h0000_0000;
    // the selects are one-hot, so the branches never overlap
    if (rd_sel[0]) begin
      next_hrdata = {24'h000000, auto_trigger_control};
    end
    if (rd_sel[1]) begin
      next_hrdata = {24'h000000, result_high};
    end
    if (rd_sel[2]) begin
      next_hrdata = {24'h000000, result_low};
    end
    if (rd_sel[3]) begin
      next_hrdata = {30'h0, conversion_go_flag, result_justify_select};
    end
    if (rd_sel[4]) begin
      next_hrdata = {29'h0, status};
    end
    if (rd_sel[5]) begin
      next_hrdata = {29'h0, mask};
    end
  end

  // held until the next read address phase, as the data phase needs
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hrdata_o <= 32'h0000_0000;
    end else if (rd_en) begin
      hrdata_o <= next_hrdata;
    end
  end

  // trigger control: only the select field is writable
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      auto_trigger_control <= ATSRF_CTRL_RST;
    end else if (wr_ctrl) begin
      auto_trigger_control <= hwdata_i[7:0] & ATSRF_CTRL_WMASK;
    end
  end

  // justification select
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      result_justify_select <= 1'b0;
    end else if (wr_cfg) begin
      result_justify_select <= hwdata_i[ATSRF_CFG_JUSTIFY];
    end
  end

  // interrupt mask, same layout as status
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mask <= 3'h0;
    end else if (wr_mask) begin
      mask <= hwdata_i[2:0];
    end
  end

  // conversion sequencing: trigger and software go share one start path
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state <= ATSRF_IDLE;
    end else begin
      case (state)
        ATSRF_IDLE: begin
          if (sw_go || trig_event) begin
            state <= ATSRF_BUSY;
          end
        end
        ATSRF_BUSY: begin
          if (conv_end || conv_cut) begin
            state <= ATSRF_IDLE;
          end
        end
        default: begin
          state <= ATSRF_IDLE;
        end
      endcase
    end
  end

  // go flag: raised by every accepted start, dropped when the run ends or is cut
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      conversion_go_flag <= 1'b0;
    end else if (start_o) begin
      conversion_go_flag <= 1'b1;
    end else if (conv_end || conv_cut) begin
      conversion_go_flag <= 1'b0;
    end
  end

  // end of a running conversion: completion beats a stop in the same cycle
  assign busy = (state == ATSRF_BUSY);
  assign conv_end = busy && conv_done_i;
  assign conv_cut = busy && !conv_done_i && (sw_stop || conv_abort_i);

  // a start pulse only when a new conversion is accepted;
  // a trigger that lands while a run is busy is dropped
  assign start_o = (state == ATSRF_IDLE) && (sw_go || trig_event);
  assign conversion_go_flag_o = conversion_go_flag;

  // result load on completion or on abort with the partial value;
  // the core's value is taken in the ending cycle, before it can go idle
  assign partial = atsrf_fill(conv_value_i, conv_bits_done_i);
  assign load_result = conv_end || conv_cut;
  assign load_value = conv_done_i ? conv_value_i : partial;
  assign formatted = atsrf_format(load_value, result_justify_select);

  // result registers have no reset so their contents survive device resets;
  // a conversion load beats a software write in the same cycle
  always_ff @(posedge clock_i) begin
    if (load_result) begin
      result_high <= formatted[15:8];
    end else if (wr_resh) begin
      result_high <= hwdata_i[7:0];
    end
  end

  always_ff @(posedge clock_i) begin
    if (load_result) begin
      result_low <= formatted[7:0];
    end else if (wr_resl) begin
      result_low <= hwdata_i[7:0];
    end
  end

  // sticky events; a set in the clear cycle wins,
  // so an event that lands with a software clear is never lost
  assign status_set[ATSRF_ST_DONE] = conv_end;
  assign status_set[ATSRF_ST_TRIG] = trig_event;
  assign status_set[ATSRF_ST_ABORT] = conv_cut;
  always_comb begin
    next_status = status;
    if (wr_stat) begin
      next_status = status & ~(hwdata_i[2:0] & ATSRF_ST_WMASK);
    end
    next_status = next_status | status_set;
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      status <= 3'h0;
    end else begin
      status <= next_status;
    end
  end

  assign conversion_done_flag_o = status[ATSRF_ST_DONE];
  // level interrupt: high while any unmasked status bit is set
  assign irq_o = |(status & mask);
endmodule : atsrf_top

/* hw/atsrf_pkg.sv */
// atsrf_pkg: constants for the converter trigger select and result format block
// assumes a 32-bit AHB-Lite register bus and a 10-bit converter core outside the block
//
// Notes on behaviour
// - 3-bit trigger select in control bits 6..4; codes 001 and 010 never trigger.
// - code 000 gives no automatic start; software go bit only.
// - 011 eight-bit timer overflow, 100 sixteen-bit overflow, 101 period match.
// - 110 rising edge of trigger pin, 111 falling edge.
// - a timer event used as trigger still sets that timer's own flag.
// - control bit 7 and bits 3..0 ignore writes and read as zero.
// - left justified: high register holds result bits 9..2.
// - left justified: low register holds bits 1..0 in positions 7..6.
// - right justified: high register holds bits 9..8 in positions 1..0.
// - right justified: low register holds result bits 7..0.
// - control resets to zero; result registers keep contents over reset; both R/W.
// - on result load the six unused bits are forced to zero.
// - a trigger event starts conversion exactly like software setting the go bit.
// - on completion clear go bit, set done flag, load result registers.
// - on abort load partial result, unconverted bits copy the last converted bit.
package atsrf_pkg;
  localparam logic [7:0] ATSRF_OFS_CTRL = 8'h00; // auto_trigger_control
  localparam logic [7:0] ATSRF_OFS_RESH = 8'h04; // result_high
  localparam logic [7:0] ATSRF_OFS_RESL = 8'h08; // result_low
  localparam logic [7:0] ATSRF_OFS_CFG = 8'h0c; // justify, go bit
  localparam logic [7:0] ATSRF_OFS_STAT = 8'h10; // sticky events
  localparam logic [7:0] ATSRF_OFS_MASK = 8'h14; // interrupt mask
  localparam int ATSRF_SEL_LSB = 4;
  localparam int ATSRF_SEL_MSB = 6;
  localparam logic [7:0] ATSRF_CTRL_WMASK = 8'h70;
  localparam logic [7:0] ATSRF_CTRL_RST = 8'h00;
  localparam int ATSRF_CFG_JUSTIFY = 0; // 1 = right justified
  localparam int ATSRF_CFG_GO = 1;
  localparam int ATSRF_ST_DONE = 0;
  localparam int ATSRF_ST_TRIG = 1;
  localparam int ATSRF_ST_ABORT = 2;
  localparam logic [2:0] ATSRF_ST_WMASK = 3'h7;
  localparam logic [2:0] ATSRF_TRG_NONE = 3'h0;
  localparam logic [2:0] ATSRF_TRG_T8 = 3'h3;
  localparam logic [2:0] ATSRF_TRG_T16 = 3'h4;
  localparam logic [2:0] ATSRF_TRG_PM = 3'h5;
  localparam logic [2:0] ATSRF_TRG_RISE = 3'h6;
  localparam logic [2:0] ATSRF_TRG_FALL = 3'h7;
  localparam int ATSRF_RES_W = 10;
  localparam logic [1:0] ATSRF_HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] ATSRF_HSIZE_WORD = 3'h2;
endpackage : atsrf_pkg

/* hw/atsrf_trig_sync.sv */
// atsrf_trig_sync: synchroniser and edge detector for the external trigger pin
// assumes the pin is asynchronous to clock_i and any edge lasts over two clocks
`timescale 1ns/10ps
module atsrf_trig_sync (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic pin_i,
  output logic rise_o,
  output logic fall_o
);
  logic meta;
  logic sync;
  logic last;

  // two stages; meta is read only by sync
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta <= 1'b0;
      sync <= 1'b0;
      last <= 1'b0;
    end else begin
      meta <= pin_i;
      sync <= meta;
      last <= sync;
    end
  end

  // one pulse per edge, since last trails sync by exactly one cycle
  assign rise_o = sync & ~last;
  assign fall_o = ~sync & last;
endmodule : atsrf_trig_sync

/* test/atsrf_props.sv */
// atsrf_props: sequencing checks on the ports of atsrf_top
// assumes one clock domain and the zero-wait bus of the block
`timescale 1ns/10ps
module atsrf_props (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  input wire logic eight_bit_overflow_i,
  input wire logic sixteen_bit_overflow_i,
  input wire logic period_match_i,
  input wire logic eight_bit_overflow_flag_o,
  input wire logic sixteen_bit_overflow_flag_o,
  input wire logic period_match_flag_o,
  input wire logic start_o,
  input wire logic conv_done_i,
  input wire logic conversion_go_flag_o,
  input wire logic conversion_done_flag_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  bus_okay_a: assert property (hreadyout_o && !hresp_o)
    else $error("bus answer not zero-wait okay");
  t8_flag_a: assert property (eight_bit_overflow_flag_o == eight_bit_overflow_i)
    else $error("eight bit timer flag lost");
  t16_flag_a: assert property (sixteen_bit_overflow_flag_o == sixteen_bit_overflow_i)
    else $error("sixteen bit timer flag lost");
  pm_flag_a: assert property (period_match_flag_o == period_match_i)
    else $error("period match flag lost");
  start_go_a: assert property (start_o |=> conversion_go_flag_o)
    else $error("start without go flag");
  start_idle_a: assert property (start_o |-> !conversion_go_flag_o)
    else $error("start while busy");
  done_clear_a: assert property (conv_done_i && conversion_go_flag_o |=>
    !conversion_go_flag_o && conversion_done_flag_o) else $error("completion not recorded");
  done_cause_a: assert property ($rose(conversion_done_flag_o) |-> $past(conv_done_i))
    else $error("done flag without completion");
endmodule : atsrf_props
bind atsrf_top atsrf_props atsrf_props_i (.clock_i(clock_i), .nrst_i(nrst_i),
  .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .eight_bit_overflow_i(eight_bit_overflow_i),
  .sixteen_bit_overflow_i(sixteen_bit_overflow_i), .period_match_i(period_match_i),
  .eight_bit_overflow_flag_o(eight_bit_overflow_flag_o),
  .sixteen_bit_overflow_flag_o(sixteen_bit_overflow_flag_o),
  .period_match_flag_o(period_match_flag_o), .start_o(start_o), .conv_done_i(conv_done_i),
  .conversion_go_flag_o(conversion_go_flag_o), .conversion_done_flag_o(conversion_done_flag_o));

/* test/atsrf_core_model.sv */
// atsrf_core_model: converter core model, one result bit per clock
// assumes start_i pulses only while idle; stall_i freezes the bit count
`timescale 1ns/10ps
module atsrf_core_model (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic start_i,
  input wire logic go_i,
  input wire logic stall_i,
  input wire logic [9:0] value_i,
  output logic done_o,
  output logic [9:0] value_o,
  output logic [3:0] bits_o
);
  logic busy;
  // a cleared go bit halts the core like an early stop
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      busy <= 1'b0;
      bits_o <= 4'h0;
    end else if (start_i) begin
      busy <= 1'b1;
      bits_o <= 4'h0;
    end else if (busy && (done_o || !go_i)) begin
      busy <= 1'b0;
    end else if (busy && !stall_i) begin
      bits_o <= bits_o + 4'h1;
    end
  end
  assign done_o = busy && go_i && bits_o == 4'ha;
  // idle value is inverted so a stale result never looks right
  assign value_o = busy ? value_i : ~value_i;
endmodule : atsrf_core_model

/* test/tb_adc_trigger_select_and_result_format.sv */
// tb_adc_trigger_select_and_result_format: trigger, result and register checks
// assumes the zero-wait slave and the core model atsrf_core_model
`timescale 1ns/10ps
module tb_adc_trigger_select_and_result_format import atsrf_pkg::*;;
  logic clock_i = 0, nrst_i = 0, hsel = 0, hwrite = 0, pin = 0, stall = 0, rd_ph = 0;
  logic hrdy, start, go, irq, cdone;
  logic [31:0] haddr = 0, hwdata = 0, rnd = 32'h1b, hrdata;
  logic [1:0] htrans = 0;
  logic [2:0] tev = 0;
  logic [9:0] cval = 0, cv, p;
  logic [3:0] bits;
  logic [7:0] eh, el;
  logic [32:0] exp_q[$];
  int n_mismatch = 0, compares = 0, b;
  always #5 clock_i = ~clock_i;
  atsrf_top atsrf_top_i (.clock_i(clock_i), .nrst_i(nrst_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(ATSRF_HSIZE_WORD), .hwdata_i(hwdata),
    .hready_i(hrdy), .hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(),
    .eight_bit_overflow_i(tev[0]), .sixteen_bit_overflow_i(tev[1]), .period_match_i(tev[2]),
    .external_trigger_pin_i(pin), .eight_bit_overflow_flag_o(), .sixteen_bit_overflow_flag_o(),
    .period_match_flag_o(), .start_o(start), .conv_done_i(cdone), .conv_abort_i(1'b0),
    .conv_value_i(cv), .conv_bits_done_i(bits), .conversion_go_flag_o(go),
    .conversion_done_flag_o(), .irq_o(irq));
  atsrf_core_model atsrf_core_model_i (.clock_i(clock_i), .nrst_i(nrst_i), .start_i(start),
    .go_i(go), .stall_i(stall), .value_i(cval), .done_o(cdone), .value_o(cv), .bits_o(bits));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  task automatic chk(input logic [32:0] seen, input logic [32:0] want);
    compares++;
    if (seen !== want) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : chk
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : test_done
  // one whole-word transfer; a read notes its expected {irq, data}
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= ATSRF_HTRANS_NONSEQ;
    hsel <= 1'b1;
    do @(posedge clock_i); while (hrdy !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    if (!w) exp_q.push_back(e);
    do @(posedge clock_i); while (hrdy !== 1'b1);
  endtask : bus
  task automatic load(input logic [9:0] v, input logic j);
    eh = j ? {6'h0, v[9:8]} : v[9:2];
    el = j ? v[7:0] : {v[1:0], 6'h0};
  endtask : load
  // read data taken at the edge that ends the data phase, as the master does
  always @(posedge clock_i) begin
    if (rd_ph && hrdy) chk({irq, hrdata}, exp_q.pop_front());
    if (hrdy) rd_ph <= hsel && htrans[1] && !hwrite;
  end
  initial begin
    repeat (20000) @(posedge clock_i);
    n_mismatch++;
    test_done();
  end
  initial begin
    repeat (6) @(posedge clock_i);
    nrst_i <= 1'b1;
    @(posedge clock_i);
    bus(1, ATSRF_OFS_MASK, 32'h1, 0);
    // codes 3..7 then 0..2, every event source fired under each code
    for (int c = 3; c < 11; c++) begin
      rnd = xs(rnd);
      cval <= rnd[9:0];
      bus(1, ATSRF_OFS_CTRL, {24'h0, rnd[31], 3'(c), rnd[3:0]}, 0);
      bus(0, ATSRF_OFS_CTRL, 0, {26'h0, 3'(c), 4'h0});
      bus(1, ATSRF_OFS_CFG, 32'(c & 1), 0);
      for (int k = 0; k < 5; k++) begin
        if (k < 3) tev <= 3'h1 << k;
        else pin <= (k == 3);
        @(posedge clock_i);
        tev <= 3'h0;
        repeat (20) @(posedge clock_i);
      end
      if (c < 8) load(rnd[9:0], c[0]);
      bus(0, ATSRF_OFS_CFG, 0, {c < 8, 32'(c & 1)});
      bus(0, ATSRF_OFS_STAT, 0, {c < 8, 30'h0, c < 8, c < 8});
      bus(1, ATSRF_OFS_STAT, 32'h7, 0);
      bus(0, ATSRF_OFS_RESH, 0, {25'h0, eh});
      bus(0, ATSRF_OFS_RESL, 0, {25'h0, el});
      $display("trigger code %0d finished", 3'(c));
    end
    // early stop: stalled core, go cleared, partial result expected
    repeat (2) @(posedge clock_i);
    bus(1, ATSRF_OFS_CFG, 32'h2, 0);
    repeat (5) @(posedge clock_i);
    stall <= 1'b1;
    repeat (2) @(posedge clock_i);
    b = int'(bits);
    for (int i = 0; i < 10; i++) p[9-i] = (i < b) ? cval[9-i] : cval[10-b];
    bus(1, ATSRF_OFS_CFG, 32'h0, 0);
    stall <= 1'b0;
    load(p, 1'b0);
    bus(0, ATSRF_OFS_RESH, 0, {25'h0, eh});
    bus(0, ATSRF_OFS_RESL, 0, {25'h0, el});
    bus(0, ATSRF_OFS_STAT, 0, 33'h4);
    bus(1, ATSRF_OFS_MASK, 32'h7, 0);
    bus(0, ATSRF_OFS_STAT, 0, 33'h100000004);
    bus(1, ATSRF_OFS_STAT, 32'h4, 0);
    bus(0, ATSRF_OFS_STAT, 0, 33'h0);
    bus(0, 8'h20, 0, 33'h0);
    $display("early stop finished");
    // result kept and control cleared across a second reset
    el = rnd[15:8];
    bus(1, ATSRF_OFS_RESL, {24'h0, el}, 0);
    bus(1, ATSRF_OFS_CTRL, 32'h30, 0);
    nrst_i <= 1'b0;
    repeat (3) @(posedge clock_i);
    nrst_i <= 1'b1;
    @(posedge clock_i);
    bus(0, ATSRF_OFS_CTRL, 0, 33'h0);
    bus(0, ATSRF_OFS_RESH, 0, {25'h0, eh});
    bus(0, ATSRF_OFS_RESL, 0, {25'h0, el});
    $display("reset retention finished");
    repeat (2) @(posedge clock_i);
    test_done();
  end
endmodule : tb_adc_trigger_select_and_result_format
